// [core/rtd_pkg.sv]
// Contract
// - Adjustable delay sits in the master receive path right after the elastic buffer.
// - Receive pipeline holds N registers, N equal to two to the power B.
// - Auto calibration runs only while control bits 25:24 hold 01.
// - Number of stages passed is changed so measured delay approaches the target.
// - While enabled, status reads 10 when tracking, 11 when target cannot be met.
// - Start with N/2 plus one stages in the path.
// - Read pointer moves at most N/2 minus one from its start.
// - Measured delay above target shortens the pipeline by one cycle.
// - Measured delay below target lengthens the pipeline by one cycle.
// - Transmit bitslip complements the receive word-aligner slip.
// - Receive slip and current transmit bitslip are readable fields.
// - Automatic bitslip compensation runs while the override enable is zero.
// - In master clocking mode the reported receive slip is zero.
// - Override enable one makes transmit bitslip follow a software value.
// - Measured delay spans transmit frame start to receive frame start.
package rtd_pkg;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_CAL = 8'h00;
  localparam logic [7:0] OFF_MEAS = 8'h04;
  localparam logic [7:0] OFF_SLIP = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
  // Calibration register fields
  localparam int CAL_USR_LSB = 0;
  localparam int CAL_USR_W = 20;
  localparam int CAL_CTRL_LSB = 24;
  localparam int CAL_STAT_LSB = 26;
  localparam logic [1:0] CAL_CTRL_AUTO = 2'h1;
  localparam logic [1:0] ST_OFF = 2'h0;
  localparam logic [1:0] ST_TRACK = 2'h2;
  localparam logic [1:0] ST_FAIL = 2'h3;
  // Bitslip register fields
  localparam int SLIP_W = 5;
  localparam int SL_RX_LSB = 0;
  localparam int SL_TX_LSB = 8;
  localparam int SL_EN_BIT = 16;
  localparam int SL_MAN_LSB = 20;
  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int IRQ_STEP = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_MEAS = 2;
  localparam logic [31:0] RESET_WORD = 32'h0;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } rtd_word_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rtd_apb_req_t;
endpackage

// [core/rtd_pipe.sv]
`timescale 1ns/1ps
module rtd_pipe
#(
  parameter int B = 3
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Stream in from elastic buffer
  input rtd_pkg::rtd_word_t i_word,
  // Number of stages passed, 1..N
  input wire logic [B:0] i_depth,
  // Stream out
  output rtd_pkg::rtd_word_t o_word
);
  import rtd_pkg::*;
  localparam int N = 2 ** B;

  if (B < 2 || B > 10)
  begin : g_bad_depth
    $error("rtd_pipe: B out of range");
  end

  rtd_word_t stage_reg [N];

  // Full shift chain; the tap picks how many stages the data passes
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < N; k++)
        stage_reg[k] <= '0;
    end
    else
    begin
      stage_reg[0] <= i_word;
      for (int k = 1; k < N; k++)
        stage_reg[k] <= stage_reg[k-1];
    end
  end

  // Depth is kept in 1..N by the caller, so the index never wraps
  assign o_word = stage_reg[B'(i_depth - 1'b1)];
endmodule

// [core/rtd_cal.sv]
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module rtd_cal
#(
  parameter int B = 3,
  parameter int RTD_W = 20
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // APB slave
  input rtd_pkg::rtd_apb_req_t i_apb,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // Receive stream
  input rtd_pkg::rtd_word_t i_rx_word,
  output rtd_pkg::rtd_word_t o_rx_word,
  // Frame marks for delay measurement
  input wire logic i_tx_frame_start,
  input wire logic i_rx_frame_start,
  // Bitslip
  input wire logic i_master_mode,
  input wire logic [rtd_pkg::SLIP_W-1:0] i_rx_slip,
  output logic [rtd_pkg::SLIP_W-1:0] o_tx_bitslip,
  // Interrupt
  output logic o_irq
);
  import rtd_pkg::*;
  localparam int N = 2 ** B;
  localparam logic [B:0] D_INIT = (B+1)'(N / 2 + 1);
  localparam logic [B:0] D_MIN = (B+1)'(N / 2 + 1 - (N / 2 - 1));
  localparam logic [B:0] D_MAX = (B+1)'(N / 2 + 1 + (N / 2 - 1));

  if (RTD_W < 2 || RTD_W > CAL_USR_W)
  begin : g_bad_width
    $error("rtd_cal: RTD_W out of range");
  end

  function automatic logic [31:0] place(input logic [31:0] v, input int lsb);
    place = v << lsb;
  endfunction

  // Bus decode
  logic wr_en;
  logic rd_setup;
  logic mapped;
  assign wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign rd_setup = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
  always_comb
  begin
    case (i_apb.paddr)
      OFF_CAL, OFF_MEAS, OFF_SLIP, OFF_IRQ_STAT, OFF_IRQ_EN, OFF_IRQ_CLR:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end
  assign o_pready = 1'b1;
  assign o_pslverr = i_apb.psel & i_apb.penable & ~mapped;

  // Software fields
  logic [RTD_W-1:0] usr_reg;
  logic [1:0] ctrl_reg;
  logic slip_en_reg;
  logic [SLIP_W-1:0] slip_man_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      usr_reg <= '0;
      ctrl_reg <= '0;
      slip_en_reg <= 1'b0;
      slip_man_reg <= '0;
      irq_en_reg <= '0;
    end
    else if (wr_en)
    begin
      case (i_apb.paddr)
        OFF_CAL:
        begin
          usr_reg <= i_apb.pwdata[CAL_USR_LSB +: RTD_W];
          ctrl_reg <= i_apb.pwdata[CAL_CTRL_LSB +: 2];
        end
        OFF_SLIP:
        begin
          slip_en_reg <= i_apb.pwdata[SL_EN_BIT];
          slip_man_reg <= i_apb.pwdata[SL_MAN_LSB +: SLIP_W];
        end
        OFF_IRQ_EN:
          irq_en_reg <= i_apb.pwdata[IRQ_W-1:0];
        default:
          irq_en_reg <= irq_en_reg;
      endcase
    end
  end

  logic cal_on;
  assign cal_on = (ctrl_reg == CAL_CTRL_AUTO);

  // Round trip measured from transmit frame start to receive frame start
  logic running_reg;
  logic [RTD_W-1:0] cnt_reg;
  logic [RTD_W-1:0] meas_reg;
  logic meas_done_reg;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      running_reg <= 1'b0;
      cnt_reg <= '0;
      meas_reg <= '0;
      meas_done_reg <= 1'b0;
    end
    else
    begin
      meas_done_reg <= 1'b0;
      if (i_tx_frame_start)
      begin
        running_reg <= 1'b1;
        cnt_reg <= RTD_W'(1);
      end
      else if (running_reg && i_rx_frame_start)
      begin
        running_reg <= 1'b0;
        meas_reg <= cnt_reg;
        meas_done_reg <= 1'b1;
      end
      else if (running_reg && cnt_reg != '1)
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Pipeline depth control
  typedef enum logic [2:0]
  {
    RTD_IDLE = 3'b001,
    RTD_TRACK = 3'b010,
    RTD_FAIL = 3'b100
  } rtd_state_t;
  rtd_state_t state_reg;
  rtd_state_t state_next;
  logic [B:0] depth_reg;
  logic [B:0] depth_next;
  logic step_ev;
  logic fail_ev;

  always_comb
  begin
    state_next = state_reg;
    depth_next = depth_reg;
    step_ev = 1'b0;
    fail_ev = 1'b0;
    case (state_reg)
      RTD_IDLE:
      begin
        depth_next = D_INIT;
        if (cal_on)
          state_next = RTD_TRACK;
      end
      RTD_TRACK, RTD_FAIL:
      begin
        if (!cal_on)
        begin
          state_next = RTD_IDLE;
          depth_next = D_INIT;
        end
        else if (meas_done_reg)
        begin
          // Single step per measurement so its effect is seen first
          if (meas_reg > usr_reg)
          begin
            if (depth_reg > D_MIN)
            begin
              depth_next = depth_reg - 1'b1;
              step_ev = 1'b1;
            end
            else
            begin
              state_next = RTD_FAIL;
              fail_ev = 1'b1;
            end
          end
          else if (meas_reg < usr_reg)
          begin
            if (depth_reg < D_MAX)
            begin
              depth_next = depth_reg + 1'b1;
              step_ev = 1'b1;
            end
            else
            begin
              state_next = RTD_FAIL;
              fail_ev = 1'b1;
            end
          end
        end
      end
      default:
      begin
        state_next = RTD_IDLE;
        depth_next = D_INIT;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= RTD_IDLE;
      depth_reg <= D_INIT;
    end
    else
    begin
      state_reg <= state_next;
      depth_reg <= depth_next;
    end
  end

  logic [1:0] status;
  always_comb
  begin
    case (state_reg)
      RTD_TRACK:
        status = ST_TRACK;
      RTD_FAIL:
        status = ST_FAIL;
      default:
        status = ST_OFF;
    endcase
  end

  // Delay inserted directly behind the elastic buffer
  rtd_pipe #(
    .B(B)
  ) u_pipe (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_word(i_rx_word),
    .i_depth(depth_reg),
    .o_word(o_rx_word)
  );

  // Bitslip; master clocking has no word-aligner slip to mirror
  logic [SLIP_W-1:0] rx_slip_rep;
  logic [SLIP_W-1:0] tx_slip_reg;
  assign rx_slip_rep = i_master_mode ? '0 : i_rx_slip;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      tx_slip_reg <= '0;
    else if (slip_en_reg)
      tx_slip_reg <= slip_man_reg;
    else
      tx_slip_reg <= rx_slip_rep;
  end
  assign o_tx_bitslip = tx_slip_reg;

  // Sticky events; a set in the clear cycle wins
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_set = {meas_done_reg, fail_ev, step_ev};
  assign irq_clr = (wr_en && i_apb.paddr == OFF_IRQ_CLR) ? i_apb.pwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
  end
  assign o_irq = |(irq_stat_reg & irq_en_reg);

  // Read data is latched in the setup cycle and stands through access
  logic [31:0] rdata;
  always_comb
  begin
    case (i_apb.paddr)
      OFF_CAL:
        rdata = place(32'(usr_reg), CAL_USR_LSB) | place(32'(ctrl_reg), CAL_CTRL_LSB)
              | place(32'(status), CAL_STAT_LSB);
      OFF_MEAS:
        rdata = 32'(meas_reg);
      OFF_SLIP:
        rdata = place(32'(rx_slip_rep), SL_RX_LSB) | place(32'(tx_slip_reg), SL_TX_LSB)
              | place(32'(slip_en_reg), SL_EN_BIT) | place(32'(slip_man_reg), SL_MAN_LSB);
      OFF_IRQ_STAT:
        rdata = 32'(irq_stat_reg);
      OFF_IRQ_EN:
        rdata = 32'(irq_en_reg);
      default:
        rdata = RESET_WORD;
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_prdata <= RESET_WORD;
    else if (rd_setup)
      o_prdata <= rdata;
  end

  depth_range_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    depth_reg >= D_MIN && depth_reg <= D_MAX)
    else $error("depth out of range");
  start_depth_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == RTD_IDLE |=> depth_reg == D_INIT)
    else $error("depth not reset to start");
  shorten_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cal_on && state_reg != RTD_IDLE && meas_done_reg && meas_reg > usr_reg && depth_reg > D_MIN
    |=> depth_reg == $past(depth_reg) - 1'b1)
    else $error("no shorten step");
  lengthen_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cal_on && state_reg != RTD_IDLE && meas_done_reg && meas_reg < usr_reg && depth_reg < D_MAX
    |=> depth_reg == $past(depth_reg) + 1'b1)
    else $error("no lengthen step");
  one_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cal_on && !meas_done_reg && state_reg != RTD_IDLE |=> $stable(depth_reg))
    else $error("step without measurement");
  limit_fail_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cal_on && state_reg != RTD_IDLE && meas_done_reg && meas_reg > usr_reg && depth_reg == D_MIN
    |=> status == ST_FAIL && depth_reg == D_MIN)
    else $error("limit not reported");
  status_off_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !cal_on |=> status == ST_OFF)
    else $error("status while disabled");
  slip_follow_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !slip_en_reg && !i_master_mode |=> o_tx_bitslip == $past(i_rx_slip))
    else $error("tx slip not mirrored");
  master_slip_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_master_mode && !slip_en_reg |=> o_tx_bitslip == '0)
    else $error("master slip not zero");
  manual_slip_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    slip_en_reg |=> o_tx_bitslip == $past(slip_man_reg))
    else $error("manual slip ignored");
  meas_span_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_tx_frame_start ##1 (!i_tx_frame_start && !i_rx_frame_start)
    ##1 (i_rx_frame_start && !i_tx_frame_start) |=> meas_done_reg && meas_reg == RTD_W'(2))
    else $error("measurement span wrong");
  upper_fail_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cal_on && state_reg != RTD_IDLE && meas_done_reg && meas_reg < usr_reg && depth_reg == D_MAX
    |=> status == ST_FAIL && depth_reg == D_MAX)
    else $error("upper limit not reported");
  // Free-running tick gives a check of the span that does not reuse the counter
  logic [RTD_W-1:0] tick_reg;
  logic [RTD_W-1:0] tx_tick_reg;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_reg <= '0;
      tx_tick_reg <= '0;
    end
    else
    begin
      tick_reg <= tick_reg + 1'b1;
      if (i_tx_frame_start)
        tx_tick_reg <= tick_reg;
    end
  end
  meas_tick_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    meas_done_reg |-> meas_reg == RTD_W'(tick_reg - tx_tick_reg - 1'b1))
    else $error("span differs from frame marks");
endmodule

// [verification/rtd_far.sv]
`timescale 1ns/1ps
module rtd_far
  import rtd_pkg::*;
#(
  parameter int PERIOD = 32,
  parameter int CABLE = 10
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Delayed stream back from the pipeline
  input rtd_pkg::rtd_word_t i_word,
  // Stream and frame marks toward the block
  output rtd_pkg::rtd_word_t o_word,
  output logic o_tx_frame_start,
  output logic o_rx_frame_start
);
  logic [7:0] cnt_reg;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg <= 8'h00;
      o_word <= '0;
      o_tx_frame_start <= 1'b0;
      o_rx_frame_start <= 1'b0;
    end
    else
    begin
      cnt_reg <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
      o_tx_frame_start <= (cnt_reg == 8'h00);
      // Data changes every cycle, so a stale marker never repeats by accident
      o_word.valid <= 1'b1;
      o_word.data <= {24'h000000, cnt_reg};
      // Receive frame start is seen when the marker word leaves the pipeline
      o_rx_frame_start <= i_word.valid && (i_word.data == 32'(CABLE));
    end
  end
endmodule

// [verification/rtd_cal_bench.sv]
`timescale 1ns/1ps
module rtd_cal_bench;
  import rtd_pkg::*;
  localparam int CABLE = 10;
  localparam int NST = 8;
  logic i_sys_clk;
  logic i_rst;
  logic master;
  logic pready;
  logic pslverr;
  logic irq;
  logic tx_fs;
  logic rx_fs;
  logic err;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [SLIP_W-1:0] rx_slip;
  logic [SLIP_W-1:0] tx_slip;
  rtd_apb_req_t apb;
  rtd_word_t in_word;
  rtd_word_t out_word;
  int n_mismatch = 0;
  int n_tests = 0;

  rtd_cal #(.B(3), .RTD_W(20)) dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_apb(apb),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .i_rx_word(in_word),
    .o_rx_word(out_word), .i_tx_frame_start(tx_fs), .i_rx_frame_start(rx_fs),
    .i_master_mode(master), .i_rx_slip(rx_slip), .o_tx_bitslip(tx_slip), .o_irq(irq));

  rtd_far #(.PERIOD(32), .CABLE(CABLE)) far_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_word(out_word), .o_word(in_word), .o_tx_frame_start(tx_fs), .o_rx_frame_start(rx_fs));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [4:0] got, input logic [4:0] exp);
    chk_reg(32'(got), 32'(exp));
  endtask

  // Waits on pready with no cycle count assumed; only the watchdog ends a hang
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge i_sys_clk);
    apb.penable <= 1'b1;
    @(posedge i_sys_clk);
    while (pready !== 1'b1)
      @(posedge i_sys_clk);
    rd = prdata;
    err = pslverr;
    apb <= '0;
    @(posedge i_sys_clk);
  endtask

  // Returns two edges after the block took a receive frame start
  task automatic wait_meas();
    @(posedge i_sys_clk);
    while (rx_fs !== 1'b1)
      @(posedge i_sys_clk);
    repeat (2) @(posedge i_sys_clk);
  endtask

  task automatic reset_vals();
    chk_pin(tx_slip, 5'h00);
    chk_reg(32'(irq), 32'h0);
    apb_xfer(1'b0, OFF_SLIP, 32'h0);
    chk_reg(rd, 32'h0);
    chk_reg({31'h0, err}, 32'h0);
    chk_reg({31'h0, pready}, 32'h1);
    apb_xfer(1'b0, OFF_CAL, 32'h0);
    chk_reg(rd, 32'h0);
  endtask

  task automatic auto_off();
    logic [1:0] c;
    for (int i = 0; i < 3; i++)
    begin
      c = (i == 0) ? 2'h0 : 2'(i + 1);
      wait_meas();
      apb_xfer(1'b1, OFF_CAL, 32'h0000000c | (32'(c) << CAL_CTRL_LSB));
      repeat (2) wait_meas();
      apb_xfer(1'b0, OFF_MEAS, 32'h0);
      chk_reg(rd, 32'(CABLE + 2 + NST / 2));
      apb_xfer(1'b0, OFF_CAL, 32'h0);
      chk_reg(32'(rd[27:26]), 32'(ST_OFF));
    end
  endtask

  task automatic track(input int target, input int steps);
    int d;
    int nd;
    logic fail;
    d = NST / 2 + 1;
    fail = 1'b0;
    wait_meas();
    apb_xfer(1'b1, OFF_CAL, 32'h0);
    apb_xfer(1'b0, OFF_CAL, 32'h0);
    chk_reg(32'(rd[27:26]), 32'(ST_OFF));
    apb_xfer(1'b1, OFF_CAL, 32'(target) | (32'(CAL_CTRL_AUTO) << CAL_CTRL_LSB));
    repeat (steps)
    begin
      wait_meas();
      apb_xfer(1'b0, OFF_MEAS, 32'h0);
      chk_reg(rd, 32'(CABLE + 1 + d));
      nd = (CABLE + 1 + d > target) ? d - 1 : d + 1;
      if (CABLE + 1 + d != target && (nd < 2 || nd > NST))
        fail = 1'b1;
      else if (CABLE + 1 + d != target)
        d = nd;
    end
    apb_xfer(1'b0, OFF_CAL, 32'h0);
    chk_reg(32'(rd[27:26]), 32'(fail ? ST_FAIL : ST_TRACK));
  endtask

  // Second reset in mid-run, taken while calibration sits in the failed state
  task automatic mid_reset();
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    apb_xfer(1'b0, OFF_CAL, 32'h0);
    chk_reg(rd, 32'h0);
    wait_meas();
    apb_xfer(1'b0, OFF_MEAS, 32'h0);
    chk_reg(rd, 32'(CABLE + 2 + NST / 2));
  endtask

  task automatic irq_flow();
    apb_xfer(1'b0, OFF_IRQ_STAT, 32'h0);
    chk_reg(rd, 32'h7);
    apb_xfer(1'b1, OFF_CAL, 32'h0);
    apb_xfer(1'b1, OFF_IRQ_CLR, 32'h7);
    apb_xfer(1'b1, OFF_IRQ_EN, 32'h3);
    wait_meas();
    apb_xfer(1'b0, OFF_IRQ_STAT, 32'h0);
    chk_reg(rd, 32'h4);
    chk_reg(32'(irq), 32'h0);
    apb_xfer(1'b1, OFF_IRQ_EN, 32'h4);
    chk_reg(32'(irq), 32'h1);
    apb_xfer(1'b1, OFF_IRQ_CLR, 32'h4);
    chk_reg(32'(irq), 32'h0);
    apb_xfer(1'b0, OFF_IRQ_STAT, 32'h0);
    chk_reg(rd, 32'h0);
  endtask

  task automatic slip_flow();
    rx_slip <= 5'h0b;
    repeat (2) @(posedge i_sys_clk);
    chk_pin(tx_slip, 5'h0b);
    apb_xfer(1'b0, OFF_SLIP, 32'h0);
    chk_reg(rd, 32'h00000b0b);
    master <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    apb_xfer(1'b0, OFF_SLIP, 32'h0);
    chk_reg(rd, 32'h0);
    apb_xfer(1'b1, OFF_SLIP, 32'h01510000);
    @(posedge i_sys_clk);
    chk_pin(tx_slip, 5'h15);
    master <= 1'b0;
    apb_xfer(1'b1, OFF_SLIP, 32'h0);
    @(posedge i_sys_clk);
    chk_pin(tx_slip, 5'h0b);
  endtask

  task automatic bad_addr();
    apb_xfer(1'b0, 8'h18, 32'h0);
    chk_reg({31'h0, err}, 32'h1);
    chk_reg(rd, 32'h0);
  endtask

  initial
  begin
    i_rst = 1'b1;
    apb = '0;
    master = 1'b0;
    rx_slip = 5'h00;
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    reset_vals();
    auto_off();
    track(14, 4);
    track(18, 4);
    track(4, 6);
    mid_reset();
    track(40, 6);
    irq_flow();
    slip_flow();
    bad_addr();
    tally_and_finish();
  end

  // About 1150 cycles are needed; this leaves ample margin
  initial
  begin
    repeat (6000) @(posedge i_sys_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
